// File: shared/slr_cfg.svh
// Purpose: named constants of the serial link receiver framer
// Assumes: included by bare name from the design file
// Notes: definitions only
`ifndef SLR_CFG_SVH
`define SLR_CFG_SVH
// ****************
// framing
// ****************
`define SLR_BIT_LAST 4'h9
`define SLR_BCLK_RISE 4'h2
`define SLR_BCLK_FALL 4'h7
`define SLR_SYNC_NEG 10'h0FA
`define SLR_SYNC_POS 10'h305
`define SLR_DBL_BYTES 12'h800
`define SLR_BIT_ONE 4'h1
`define SLR_RF_ONE 12'h001
// ****************
// self-test
// ****************
`define SLR_ST_LAST 9'h1FE
`define SLR_ST_SEED 9'h1FF
`define SLR_ST_ONE 9'h001
// ****************
// data word and inputs
// ****************
`define SLR_WORD_W 11
`define SLR_FIFO_DEPTH 16
`define SLR_W_RDYN 10
`define SLR_W_VIOL 9
`define SLR_W_KIND 8
`define SLR_IN_W 7
`define SLR_IN_RST 7'h40
`define SLR_I_PRI 0
`define SLR_I_SEC 1
`define SLR_I_SEL 2
`define SLR_I_SI 3
`define SLR_I_RF 4
`define SLR_I_MODE 5
`define SLR_I_STN 6
`endif

// File: shared/slr_pkg.sv
// Purpose: types of the serial link receiver framer
// Assumes: nothing
// Notes: constants live in slr_cfg.svh
package slr_pkg;
   typedef enum logic [1:0] {SLR_ST_OFF, SLR_ST_WAIT, SLR_ST_RUN} slr_st_e;
   typedef logic [10:0] slr_word_t;
endpackage : slr_pkg

// File: hw/slr_top.sv
// Purpose: receive framer, decoder, self-test check and output stage
// Assumes: clk runs at the serial bit rate, 250 MHz
// Notes: one output word per byte time, through a 16-word fifo
`timescale 1ns/1ps
`include "slr_cfg.svh"

// ****************
// two-flop synchroniser
// ****************
module slr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   // first stage read only by the second
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= RST;
         q <= RST;
      end else begin
         s1_r <= d;
         q <= s1_r;
      end
   end
endmodule : slr_sync

// ****************
// fifo
// ****************
module slr_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   // honest flags straight from the count
   assign in_ready = cnt_r != FULL;
   assign out_valid = cnt_r != '0;
   assign out_data = mem[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end
   // pointers wrap because depth is a power of two
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_r <= wr_r + AW'(push);
         rd_r <= rd_r + AW'(pop);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : slr_fifo

// Summary of operation
// [RQ1] outputs show the latest decoded byte, updated with the byte clock
// [RQ2] unencoded mode shows raw bits: a on kind, b..h on data, j on violation
// [RQ3] kind flag high for special character, low for data
// [RQ4] violation flag high on a code rule violation, else low
// [RQ5] in self-test violation flag low for each byte matching the sequence
// [RQ6] valid strobe pulses low per new byte, none for the pad character
// [RQ7] in self-test valid strobe low except one high byte per loop
// [RQ8] byte clock follows the stream; outputs switch on its rising edge
// [RQ9] line select high takes the primary input, low the secondary
// [RQ10] status output follows the status input
// [RQ11] reframe enable high realigns the boundary on every sync symbol; in double-byte mode the code realigns only on two syncs in a row
// [RQ12] reframe enable high 2,048 bytes switches framer to double-byte
// [RQ13] reframe enable low keeps boundaries of the internal bit counter
// [RQ14] mode low decodes 8B/10B, mode high bypasses the decoder
// [RQ15] self-test waits for D0.0 before comparing the sequence
// [RQ16] a detected sync fills one byte slot; counting restarts after it
module slr_top
   import slr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // line pins
   input wire logic serial_in_primary,
   input wire logic serial_in_secondary,
   input wire logic line_select,
   input wire logic status_in,
   output logic status_out,
   // control pins
   input wire logic reframe_enable,
   input wire logic mode_unencoded,
   input wire logic self_test_enable_n,
   // parallel output
   input wire logic rx_take,
   output logic recovered_byte_clock,
   output logic [7:0] rx_byte_out,
   output logic char_kind_flag,
   output logic code_violation_flag,
   output logic rx_valid_n,
   output logic fifo_overflow
);
   logic [`SLR_IN_W-1:0] in_s;
   logic pri_s, sec_s, sel_s, si_s, rf_s, mode_s, stn_s;
   logic ser;
   logic [19:0] sh_r;
   logic [3:0] bit_cnt_r;
   logic sync_lo, sync_hi, realign, latch;
   logic [9:0] sym_r;
   logic push_v_r;
   logic [11:0] rf_cnt_r;
   logic dbl_r;
   slr_st_e st_r;
   logic [8:0] lfsr_r;
   logic [8:0] loop_r;
   logic [9:0] dec;
   logic [7:0] raw_b;
   logic is_pad, d00;
   slr_word_t word;
   logic f_rdy, f_val, upd, pop;
   slr_word_t f_out;

   // ****************
   // 8B/10B decode: {violation, kind, byte}
   // ****************
   function automatic logic [9:0] slr_dec(input logic [9:0] s);
      logic [4:0] lo;
      logic [2:0] hi;
      logic [3:0] f;
      logic b6, b4, k28, a7;
      lo = 5'h00;
      hi = 3'h0;
      b6 = 1'b0;
      b4 = 1'b0;
      case (s[9:4])
         6'h27, 6'h18: lo = 5'h00;
         6'h1D, 6'h22: lo = 5'h01;
         6'h2D, 6'h12: lo = 5'h02;
         6'h31: lo = 5'h03;
         6'h35, 6'h0A: lo = 5'h04;
         6'h29: lo = 5'h05;
         6'h19: lo = 5'h06;
         6'h38, 6'h07: lo = 5'h07;
         6'h39, 6'h06: lo = 5'h08;
         6'h25: lo = 5'h09;
         6'h15: lo = 5'h0A;
         6'h34: lo = 5'h0B;
         6'h0D: lo = 5'h0C;
         6'h2C: lo = 5'h0D;
         6'h1C: lo = 5'h0E;
         6'h17, 6'h28: lo = 5'h0F;
         6'h1B, 6'h24: lo = 5'h10;
         6'h23: lo = 5'h11;
         6'h13: lo = 5'h12;
         6'h32: lo = 5'h13;
         6'h0B: lo = 5'h14;
         6'h2A: lo = 5'h15;
         6'h1A: lo = 5'h16;
         6'h3A, 6'h05: lo = 5'h17;
         6'h33, 6'h0C: lo = 5'h18;
         6'h26: lo = 5'h19;
         6'h16: lo = 5'h1A;
         6'h36, 6'h09: lo = 5'h1B;
         6'h0E, 6'h0F, 6'h30: lo = 5'h1C;
         6'h2E, 6'h11: lo = 5'h1D;
         6'h1E, 6'h21: lo = 5'h1E;
         6'h2B, 6'h14: lo = 5'h1F;
         default: b6 = 1'b1;
      endcase
      k28 = (s[9:4] == 6'h0F) || (s[9:4] == 6'h30);
      // positive-disparity K28 carries the complemented tail
      f = (s[9:4] == 6'h30) ? ~s[3:0] : s[3:0];
      case (f)
         4'hB, 4'h4: hi = 3'h0;
         4'h9: hi = 3'h1;
         4'h5: hi = 3'h2;
         4'hC, 4'h3: hi = 3'h3;
         4'hD, 4'h2: hi = 3'h4;
         4'hA: hi = 3'h5;
         4'h6: hi = 3'h6;
         4'hE, 4'h1, 4'h7, 4'h8: hi = 3'h7;
         default: b4 = 1'b1;
      endcase
      a7 = (f == 4'h7) || (f == 4'h8);
      return {b6 | b4, k28 || (a7 && (lo == 5'h17 || lo == 5'h1B || lo == 5'h1D
         || lo == 5'h1E)), hi, lo};
   endfunction : slr_dec

   // ****************
   // pin synchronisers
   // ****************
   slr_sync #(.W(`SLR_IN_W), .RST(`SLR_IN_RST)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({self_test_enable_n, mode_unencoded, reframe_enable, status_in,
          line_select, serial_in_secondary, serial_in_primary}),
      .q(in_s)
   );
   assign pri_s = in_s[`SLR_I_PRI];
   assign sec_s = in_s[`SLR_I_SEC];
   assign sel_s = in_s[`SLR_I_SEL];
   assign si_s = in_s[`SLR_I_SI];
   assign rf_s = in_s[`SLR_I_RF];
   assign mode_s = in_s[`SLR_I_MODE];
   assign stn_s = in_s[`SLR_I_STN];

   // ****************
   // shifter and framer
   // ****************
   assign ser = sel_s ? pri_s : sec_s; // [RQ9]
   assign sync_lo = sh_r[9:0] == `SLR_SYNC_NEG || sh_r[9:0] == `SLR_SYNC_POS;
   assign sync_hi = sh_r[19:10] == `SLR_SYNC_NEG || sh_r[19:10] == `SLR_SYNC_POS;
   // double-byte mode needs two syncs in a row, so one hit alone cannot move it
   assign realign = rf_s && sync_lo && (!dbl_r || sync_hi); // [RQ11] [RQ12]
   assign latch = realign || bit_cnt_r == `SLR_BIT_LAST; // [RQ13]
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sh_r <= '0;
         bit_cnt_r <= '0;
         sym_r <= '0;
         push_v_r <= 1'b0;
      end else begin
         sh_r <= {sh_r[18:0], ser};
         bit_cnt_r <= latch ? '0 : bit_cnt_r + `SLR_BIT_ONE; // [RQ16]
         push_v_r <= latch;
         if (latch) begin
            sym_r <= sh_r[9:0];
         end
      end
   end

   // reframe run length decides double-byte mode
   always_ff @(posedge clk) begin
      if (!rst_n || !rf_s) begin
         rf_cnt_r <= '0;
         dbl_r <= 1'b0;
      end else if (latch && !dbl_r) begin
         rf_cnt_r <= rf_cnt_r + `SLR_RF_ONE;
         dbl_r <= rf_cnt_r == `SLR_DBL_BYTES - `SLR_RF_ONE; // [RQ12]
      end
   end

   // ****************
   // decode and self-test compare
   // ****************
   assign dec = slr_dec(sym_r);
   assign is_pad = sym_r == `SLR_SYNC_NEG || sym_r == `SLR_SYNC_POS;
   assign d00 = dec == 10'h000;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         raw_b[i] = sym_r[8-i];
      end
      if (mode_s) begin
         word = {is_pad, sym_r[0], sym_r[9], raw_b}; // [RQ2] [RQ14]
      end else if (st_r == SLR_ST_RUN) begin
         // [RQ5] [RQ7]
         word = {loop_r == `SLR_ST_LAST, dec[9:0] != {2'h0, lfsr_r[7:0]}, dec[8:0]};
      end else begin
         word = {is_pad, dec}; // [RQ3] [RQ4] [RQ6] [RQ14]
      end
   end

   // self-test: wait for D0.0, then track the expected sequence
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= SLR_ST_OFF;
         lfsr_r <= `SLR_ST_SEED;
         loop_r <= '0;
      end else begin
         case (st_r)
            SLR_ST_OFF: begin
               if (!stn_s) begin
                  st_r <= SLR_ST_WAIT;
               end
            end
            SLR_ST_WAIT: begin
               if (stn_s) begin
                  st_r <= SLR_ST_OFF;
               end else if (push_v_r && d00 && !mode_s) begin
                  st_r <= SLR_ST_RUN; // [RQ15]
                  lfsr_r <= `SLR_ST_SEED;
                  loop_r <= `SLR_ST_ONE;
               end
            end
            SLR_ST_RUN: begin
               if (stn_s) begin
                  st_r <= SLR_ST_OFF;
               end else if (push_v_r) begin
                  lfsr_r <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
                  loop_r <= (loop_r == `SLR_ST_LAST) ? '0 : loop_r + `SLR_ST_ONE;
               end
            end
            default: st_r <= SLR_ST_OFF;
         endcase
      end
   end

   // ****************
   // output fifo and byte clock stage
   // ****************
   slr_fifo #(.W(`SLR_WORD_W), .D(`SLR_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push_v_r),
      .in_ready(f_rdy),
      .in_data(word),
      .out_valid(f_val),
      .out_ready(pop),
      .out_data(f_out)
   );
   assign upd = bit_cnt_r == `SLR_BCLK_RISE;
   assign pop = upd && f_val && rx_take;
   // a realign may shorten one byte clock phase; that is the price of framing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         recovered_byte_clock <= 1'b0;
         rx_byte_out <= '0;
         char_kind_flag <= 1'b0;
         code_violation_flag <= 1'b0;
         rx_valid_n <= 1'b1;
      end else begin
         // [RQ8]
         recovered_byte_clock <= bit_cnt_r >= `SLR_BCLK_RISE && bit_cnt_r < `SLR_BCLK_FALL;
         if (pop) begin
            rx_byte_out <= f_out[7:0]; // [RQ1]
            char_kind_flag <= f_out[`SLR_W_KIND];
            code_violation_flag <= f_out[`SLR_W_VIOL];
            rx_valid_n <= f_out[`SLR_W_RDYN];
         end else if (upd) begin
            rx_valid_n <= 1'b1; // no fresh byte this slot
         end
      end
   end

   // status pass-through and sticky overflow
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_out <= 1'b0;
         fifo_overflow <= 1'b0;
      end else begin
         status_out <= si_s; // [RQ10]
         fifo_overflow <= fifo_overflow || (push_v_r && !f_rdy);
      end
   end

   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_sel;
      sel_s ##1 sel_s |-> sh_r[0] == $past(pri_s);
   endproperty
   a_sel: assert property (p_sel) else $error("primary not shifted"); // [RQ9]
   property p_status;
      ##1 status_out == $past(si_s);
   endproperty
   a_status: assert property (p_status) else $error("status lag"); // [RQ10]
   property p_edge;
      $changed(rx_byte_out) |-> $rose(recovered_byte_clock);
   endproperty
   a_edge: assert property (p_edge) else $error("data off edge"); // [RQ8]
   property p_realign;
      realign |=> bit_cnt_r == '0 ##9 latch;
   endproperty
   a_realign: assert property (p_realign) else $error("bad realign"); // [RQ11]
   property p_hold;
      !rf_s && bit_cnt_r != `SLR_BIT_LAST |-> !latch;
   endproperty
   a_hold: assert property (p_hold) else $error("reframe while off"); // [RQ13]
   property p_dbl;
      !rf_s |=> !dbl_r;
   endproperty
   a_dbl: assert property (p_dbl) else $error("double mode w/o rf"); // [RQ12]
   property p_pad;
      push_v_r && is_pad && st_r != SLR_ST_RUN |-> word[`SLR_W_RDYN];
   endproperty
   a_pad: assert property (p_pad) else $error("pad marked valid"); // [RQ6]
   property p_raw;
      push_v_r && mode_s |-> word[`SLR_W_VIOL] == sym_r[0] && word[7] == sym_r[1];
   endproperty
   a_raw: assert property (p_raw) else $error("raw map wrong"); // [RQ2]
   property p_loop;
      push_v_r && st_r == SLR_ST_RUN && !mode_s && loop_r != `SLR_ST_LAST
         |-> !word[`SLR_W_RDYN];
   endproperty
   a_loop: assert property (p_loop) else $error("test strobe high"); // [RQ7]
   property p_wait;
      st_r == SLR_ST_WAIT && !(push_v_r && d00) && !stn_s |=> st_r == SLR_ST_WAIT;
   endproperty
   a_wait: assert property (p_wait) else $error("test started early"); // [RQ15]
   c_realign: cover property (realign);
   c_dbl: cover property ($rose(dbl_r));
   c_run: cover property (st_r == SLR_ST_RUN && push_v_r && !word[`SLR_W_VIOL]);
   c_ovf: cover property ($rose(fifo_overflow));
endmodule : slr_top

// File: testbench/slr_tx_model.sv
// Purpose: far-end serial transmitter feeding the receiver line
// Assumes: one line bit per clk, bit a of each symbol first
// Notes: idle time is padded with sync symbols of alternating disparity
`timescale 1ns/1ps
`include "slr_cfg.svh"

module slr_tx_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // symbol feed: item is {bit count, symbol}
   input wire logic have,
   input wire logic [13:0] item,
   output logic take,
   // line
   output logic ser
);
   logic [9:0] cur_r;
   logic [3:0] len_r;
   logic [3:0] idx_r;
   logic rd_r;

   // ****************
   // shifter
   // ****************
   // shift msb first; a short item slips the far framer on purpose
   always @(negedge clk) begin
      if (!rst_n) begin
         take <= 1'b0;
         cur_r <= `SLR_SYNC_NEG;
         len_r <= 4'hA;
         idx_r <= 4'h0;
         rd_r <= 1'b0;
         ser <= 1'b0;
      end else begin
         ser <= cur_r[4'h9 - idx_r];
         // one assignment per edge: take marks the boundary where the feed was used
         take <= have && idx_r == len_r - 4'h1;
         if (idx_r == len_r - 4'h1) begin
            idx_r <= 4'h0;
            if (have) begin
               cur_r <= item[9:0];
               len_r <= item[13:10];
            end else begin
               // pad keeps the link framed between user bytes
               cur_r <= rd_r ? `SLR_SYNC_NEG : `SLR_SYNC_POS;
               len_r <= 4'hA;
               rd_r <= ~rd_r;
            end
         end else begin
            idx_r <= idx_r + 4'h1;
         end
      end
   end
endmodule : slr_tx_model

// File: testbench/test_serial_link_receiver_framer.sv
// Purpose: self-checking bench of the receiver framer
// Assumes: expectations queued by the driver, checked at each byte clock rise
// Notes: raw mode carries random symbols; decoded mode a few fixed codes
`timescale 1ns/1ps
`include "slr_cfg.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); end end

module test_serial_link_receiver_framer;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic line_select = 1'b1;
   logic status_in = 1'b0;
   logic reframe_enable = 1'b1;
   logic mode_unencoded = 1'b1;
   logic self_test_enable_n = 1'b1;
   logic rx_take = 1'b1;
   logic have = 1'b0;
   logic [13:0] item = 14'h0000;
   logic ser, take, status_out, recovered_byte_clock;
   logic char_kind_flag, code_violation_flag, rx_valid_n, fifo_overflow;
   logic [7:0] rx_byte_out;
   logic armed = 1'b0;
   logic bclk_d = 1'b0;
   int mismatches = 0;
   int tests_run = 0;
   int seed = 8821;
   logic [13:0] tx_q[$];
   logic [10:0] exp_q[$]; // {check data, kind, violation, byte}

   always #2 clk = ~clk;

   // the unselected line carries the inverse, so a wrong pick corrupts data
   slr_top i_dut (.clk(clk), .rst_n(rst_n), .serial_in_primary(line_select ? ser : ~ser),
      .serial_in_secondary(line_select ? ~ser : ser), .line_select(line_select),
      .status_in(status_in), .status_out(status_out), .reframe_enable(reframe_enable),
      .mode_unencoded(mode_unencoded), .self_test_enable_n(self_test_enable_n),
      .rx_take(rx_take), .recovered_byte_clock(recovered_byte_clock),
      .rx_byte_out(rx_byte_out), .char_kind_flag(char_kind_flag),
      .code_violation_flag(code_violation_flag), .rx_valid_n(rx_valid_n),
      .fifo_overflow(fifo_overflow));

   slr_tx_model i_tx (.clk(clk), .rst_n(rst_n), .have(have), .item(item), .take(take),
      .ser(ser));

   // ****************
   // feed and monitor
   // ****************
   // hand the queue head to the model, drop it once taken
   always @(posedge clk) begin
      if (take && tx_q.size() != 0) tx_q.delete(0);
      have <= tx_q.size() != 0;
      if (tx_q.size() != 0) item <= tx_q[0];
   end

   // a new byte shows as a rising byte clock with the strobe low
   always @(negedge clk) begin : mon
      logic [10:0] e;
      bclk_d <= recovered_byte_clock;
      if (armed && recovered_byte_clock && !bclk_d && rx_valid_n === 1'b0) begin
         if (exp_q.size() == 0) begin
            `CHK(1'b1, 1'b0)
         end else begin
            e = exp_q.pop_front();
            `CHK(code_violation_flag, e[8])
            if (e[10]) begin
               `CHK(rx_byte_out, e[7:0])
               `CHK(char_kind_flag, e[9])
            end
         end
      end
   end

   // ****************
   // tasks
   // ****************
   function automatic logic [10:0] raw_exp(input logic [9:0] s);
      logic [7:0] b;
      b = {<<{s[8:1]}};
      return {1'b1, s[9], s[0], b};
   endfunction : raw_exp

   task automatic put(input logic [9:0] s, input logic [10:0] e, input logic chk);
      tx_q.push_back({4'hA, s});
      if (chk) exp_q.push_back(e);
   endtask : put

   // bounded wait for all queued symbols to come out, then let the pipe settle
   task automatic drain;
      int n;
      n = 0;
      while ((tx_q.size() != 0 || exp_q.size() != 0) && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000) begin
         mismatches++;
         complete_run();
      end
      // the fifo keeps a backlog after a stall, so stray words need time to leave
      repeat (200) @(negedge clk);
   endtask : drain

   task automatic complete_run;
      $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   // ****************
   // scenarios
   // ****************
   initial begin
      logic [9:0] s;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      `CHK(rx_valid_n, 1'b1)
      `CHK(fifo_overflow, 1'b0)
      $display("test reset done");
      repeat (80) @(negedge clk);
      armed = 1'b1;
      reframe_enable = 1'b0;
      for (int i = 0; i < 40; i++) begin
         if (i == 24) line_select = 1'b0;
         s = 10'($random(seed));
         if (s == `SLR_SYNC_NEG || s == `SLR_SYNC_POS) s = 10'h155;
         put(s, raw_exp(s), 1'b1);
         if (i == 10) begin
            repeat (60) @(negedge clk);
            rx_take = 1'b0;
            repeat (80) @(negedge clk);
            rx_take = 1'b1;
         end
      end
      drain();
      line_select = 1'b1;
      $display("test raw stream and line select done");
      mode_unencoded = 1'b0;
      put(10'h274, {3'b100, 8'h00}, 1'b1);
      put(10'h0F8, {3'b110, 8'hFC}, 1'b1);
      put(10'h000, {3'b001, 8'h00}, 1'b1);
      drain();
      mode_unencoded = 1'b1;
      $display("test decoded codes done");
      armed = 1'b0;
      reframe_enable = 1'b1;
      tx_q.push_back({4'h3, 10'h155});
      drain();
      armed = 1'b1;
      put(10'h155, raw_exp(10'h155), 1'b1);
      put(10'h2AA, raw_exp(10'h2AA), 1'b1);
      put(10'h333, raw_exp(10'h333), 1'b1);
      drain();
      reframe_enable = 1'b0;
      $display("test reframe done");
      for (int i = 0; i < 20; i++) begin
         status_in = 1'($random(seed));
         repeat (4) @(negedge clk);
         `CHK(status_out, status_in)
      end
      $display("test status done");
      // self-test: one data byte before the start marker, then two good and one bad
      mode_unencoded = 1'b0;
      self_test_enable_n = 1'b0;
      repeat (30) @(negedge clk);
      put(10'h2BE, {3'b100, 8'hFF}, 1'b1);
      put(10'h274, {3'b100, 8'h00}, 1'b1);
      put(10'h2BE, {3'b100, 8'hFF}, 1'b1);
      put(10'h1EE, {3'b100, 8'hFE}, 1'b1);
      put(10'h274, {3'b101, 8'h00}, 1'b1);
      // pads that follow are compared too, so stop watching once the last note is used
      for (int n = 0; exp_q.size() != 0; n++) begin
         if (n == 3000) begin
            mismatches++;
            complete_run();
         end
         @(negedge clk);
      end
      armed = 1'b0;
      self_test_enable_n = 1'b1;
      drain();
      $display("test self-test done");
      armed = 1'b0;
      rx_take = 1'b0;
      repeat (250) @(negedge clk);
      `CHK(fifo_overflow, 1'b1)
      rx_take = 1'b1;
      drain();
      $display("test overflow done");
      complete_run();
   end
endmodule : test_serial_link_receiver_framer
